// *** gps_defs.svh ***
`ifndef GPS_DEFS_SVH
`define GPS_DEFS_SVH

// Register addresses
`define GPS_ADDR_RESET_CTRL 8'h00
`define GPS_ADDR_REVISION 8'h04
`define GPS_ADDR_ADC_PAGE 8'h11
`define GPS_ADDR_CHAN_PAGE 8'h12
`define GPS_ADDR_ANALOG_PAGE 8'h13
`define GPS_ADDR_TRIM_RATE 8'h64
`define GPS_ADDR_PATTERN_LOW 8'h8d
`define GPS_ADDR_PATTERN_HIGH 8'h8e

// Field positions and writable masks
`define GPS_BIT_WRITE_ONE 7
`define GPS_BIT_SOFT_RESET 0
`define GPS_MASK_RESET_CTRL 8'h81
`define GPS_MASK_ADC_PAGE 8'hff
`define GPS_MASK_CHAN_PAGE 8'h7f
`define GPS_MASK_ANALOG_PAGE 8'h01
`define GPS_MASK_TRIM_RATE 8'h02
`define GPS_BIT_TRIM_RATE 1
`define GPS_BIT_DIGITAL_TOP_PAGE_EN 0

// Reset values
`define GPS_RESET_VALUE 8'h00

// Revision code, arbitrary neutral value
`define GPS_REVISION_DEFAULT 8'h5a

`endif

// *** gps_pkg.sv ***
package gps_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gps_req_s;

  typedef struct packed {
    logic [7:0] adc_page;
    logic [6:0] chan_page;
    logic analog_page;
  } gps_pages_s;

  typedef enum logic [1:0] {
    GPS_RUN,
    GPS_SOFT_RESET
  } gps_state_e;

endpackage

// *** gps_page_reg.sv ***
`timescale 1ns/1ps
`include "gps_defs.svh"

// One byte register with a writable mask; unwritable bits stay zero.
module gps_page_reg
  import gps_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_value
);

  typedef struct packed {
    logic [7:0] value;
  } gps_reg_state_s;

  gps_reg_state_s r;
  gps_reg_state_s next_r;

  always_comb begin
    next_r = r;
    if (i_clear) begin
      next_r.value = `GPS_RESET_VALUE;
    end else if (i_we) begin
      next_r.value = i_wdata & MASK; // [RL3]
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_value = r.value;

endmodule

// *** gps_read_mux.sv ***
`timescale 1ns/1ps
`include "gps_defs.svh"

// Read data selection; unmapped or unselected addresses read zero.
module gps_read_mux
  import gps_pkg::*;
(
  input wire logic [7:0] i_addr,
  input wire logic i_digital_top_page_sel,
  input wire logic [7:0] i_reset_ctrl,
  input wire logic [7:0] i_revision,
  input wire logic [7:0] i_adc_page,
  input wire logic [7:0] i_chan_page,
  input wire logic [7:0] i_analog_page,
  input wire logic [7:0] i_trim_rate,
  input wire logic [7:0] i_pattern_low,
  output logic [7:0] o_rdata
);

  always_comb begin
    o_rdata = 8'h00;
    case (i_addr)
      `GPS_ADDR_RESET_CTRL: o_rdata = i_reset_ctrl;
      `GPS_ADDR_REVISION: o_rdata = i_revision; // [RL4]
      `GPS_ADDR_ADC_PAGE: o_rdata = i_adc_page;
      `GPS_ADDR_CHAN_PAGE: o_rdata = i_chan_page;
      `GPS_ADDR_ANALOG_PAGE: o_rdata = i_analog_page;
      `GPS_ADDR_TRIM_RATE: o_rdata = i_digital_top_page_sel ? i_trim_rate : 8'h00;
      `GPS_ADDR_PATTERN_LOW: o_rdata = i_digital_top_page_sel ? i_pattern_low : 8'h00;
      default: o_rdata = 8'h00;
    endcase
  end

endmodule

// *** gps_regs.sv ***
// What this block does
// RL1 - The host always writes bit 7 of the reset control register as one; it resets to zero.
// RL2 - Writing one to bit 0 of the reset control register resets every configuration register.
// RL3 - Bits documented as zero are written as zero and always read back as zero.
// RL4 - The revision register shows a fixed eight-bit code and ignores writes.
// RL5 - The ADC sub-block register holds eight access enables, D second at bit 7 down to A first at bit 0.
// RL6 - All ADC sub-block page enables reset to zero so no sub-block page is selected.
// RL7 - Channel page register bit 6 selects the pair CD serializer page and bit 5 the pair AB one.
// RL8 - Channel page register bits 4 to 1 select the channel D, C, B and A pages.
// RL9 - Channel page register bit 0 selects the digital-top page, resets to zero, bit 7 stays zero.
// RL10 - Analog page register bit 0 selects the analog page and bits 7 to 1 stay zero.
// RL11 - Trim rate register bit 1 picks 375 MSPS when zero and 500 MSPS when one.
// RL12 - The pattern low register holds the low byte of user pattern one, resetting to zero.
// RL13 - User pattern one, low and high byte, is presented for the single and dual pattern modes.
// RL14 - A write reaches every selected page, a read comes from one selected page.
// RL15 - The soft reset bit clears itself once the reset completes.
`timescale 1ns/1ps
`include "gps_defs.svh"

module gps_regs
  import gps_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = `GPS_REVISION_DEFAULT
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Register access from the configuration port, same clock domain
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  // Pattern high byte, held in the part of the digital-top page outside this bank
  input wire logic [7:0] I_PATTERN_HIGH,
  // Read answer
  output logic [7:0] O_RDATA,
  output logic O_RVALID,
  // Page selects to the rest of the device
  output logic [7:0] O_ADC_PAGE_EN,
  output logic [6:0] O_CHAN_PAGE_EN,
  output logic O_ANALOG_PAGE_EN,
  // Digital-top controls and the soft device reset
  output logic O_TRIM_LOAD_RATE_SEL,
  output logic [15:0] O_USER_PATTERN_ONE,
  output logic O_SOFT_DEVICE_RESET
);

  typedef struct packed {
    gps_state_e state;
    logic [7:0] rdata;
    logic rvalid;
    gps_pages_s pages;
    logic trim_rate_sel;
    logic [15:0] pattern;
    logic soft_reset;
  } gps_top_state_s;

  gps_top_state_s r;
  gps_top_state_s next_r;

  logic [7:0] reset_ctrl;
  logic [7:0] adc_page;
  logic [7:0] chan_page;
  logic [7:0] analog_page;
  logic [7:0] trim_rate;
  logic [7:0] pattern_low;
  logic [7:0] rd_value;
  logic clear_all;
  logic digital_top_page_sel;
  logic we_reset_ctrl;
  logic we_adc;
  logic we_chan;
  logic we_analog;
  logic we_trim;
  logic we_pattern;

  // A write landing during the soft reset cycle is dropped; the reset must win.
  assign clear_all = (r.state == GPS_SOFT_RESET); // [RL2]
  assign digital_top_page_sel = chan_page[`GPS_BIT_DIGITAL_TOP_PAGE_EN]; // [RL9]
  assign we_reset_ctrl = I_WR && (I_ADDR == `GPS_ADDR_RESET_CTRL);
  assign we_adc = I_WR && (I_ADDR == `GPS_ADDR_ADC_PAGE); // [RL5]
  assign we_chan = I_WR && (I_ADDR == `GPS_ADDR_CHAN_PAGE); // [RL7] [RL8]
  assign we_analog = I_WR && (I_ADDR == `GPS_ADDR_ANALOG_PAGE); // [RL10]
  // Digital-top registers are reached only while their page is selected; the write
  // goes to that page whatever other pages are selected alongside.
  assign we_trim = I_WR && digital_top_page_sel && (I_ADDR == `GPS_ADDR_TRIM_RATE); // [RL14]
  assign we_pattern = I_WR && digital_top_page_sel && (I_ADDR == `GPS_ADDR_PATTERN_LOW); // [RL14]

  // Bit 7 is kept as written so a read shows what the host wrote [RL1]
  gps_page_reg #(.MASK(`GPS_MASK_RESET_CTRL)) u_reset_ctrl (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(clear_all),
    .i_we(we_reset_ctrl),
    .i_wdata(I_WDATA),
    .o_value(reset_ctrl)
  );

  gps_page_reg #(.MASK(`GPS_MASK_ADC_PAGE)) u_adc_page (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(clear_all),
    .i_we(we_adc),
    .i_wdata(I_WDATA),
    .o_value(adc_page)
  );

  gps_page_reg #(.MASK(`GPS_MASK_CHAN_PAGE)) u_chan_page (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(clear_all),
    .i_we(we_chan),
    .i_wdata(I_WDATA),
    .o_value(chan_page)
  );

  gps_page_reg #(.MASK(`GPS_MASK_ANALOG_PAGE)) u_analog_page (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(clear_all),
    .i_we(we_analog),
    .i_wdata(I_WDATA),
    .o_value(analog_page)
  );

  gps_page_reg #(.MASK(`GPS_MASK_TRIM_RATE)) u_trim_rate (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(clear_all),
    .i_we(we_trim),
    .i_wdata(I_WDATA),
    .o_value(trim_rate)
  );

  gps_page_reg #(.MASK(8'hff)) u_pattern_low (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(clear_all),
    .i_we(we_pattern),
    .i_wdata(I_WDATA),
    .o_value(pattern_low)
  );

  gps_read_mux u_read_mux (
    .i_addr(I_ADDR),
    .i_digital_top_page_sel(digital_top_page_sel),
    .i_reset_ctrl(reset_ctrl),
    .i_revision(REVISION_CODE),
    .i_adc_page(adc_page),
    .i_chan_page(chan_page),
    .i_analog_page(analog_page),
    .i_trim_rate(trim_rate),
    .i_pattern_low(pattern_low),
    .o_rdata(rd_value)
  );

  always_comb begin
    next_r = r;
    next_r.rvalid = I_RD;
    next_r.rdata = I_RD ? rd_value : 8'h00;
    case (r.state)
      GPS_RUN: begin
        if (we_reset_ctrl && I_WDATA[`GPS_BIT_SOFT_RESET]) begin
          next_r.state = GPS_SOFT_RESET; // [RL2]
        end
      end
      GPS_SOFT_RESET: begin
        next_r.state = GPS_RUN; // [RL15]
      end
      default: begin
        next_r.state = GPS_RUN;
      end
    endcase
    next_r.soft_reset = (next_r.state == GPS_SOFT_RESET);
    // Outputs mirror the next register contents, zeroed from the soft reset pulse on, so they leave one flop stage
    if (next_r.state == GPS_SOFT_RESET || clear_all) begin
      next_r.pages = '0; // [RL6]
      next_r.trim_rate_sel = 1'b0;
      // The high byte lives outside this bank, so it keeps tracking its input
      next_r.pattern = {I_PATTERN_HIGH, 8'h00}; // [RL2] [RL13]
    end else begin
      next_r.pages.adc_page = we_adc ? I_WDATA : adc_page; // [RL5] [RL6]
      next_r.pages.chan_page = we_chan ? I_WDATA[6:0] : chan_page[6:0]; // [RL7] [RL8]
      next_r.pages.analog_page = we_analog ? I_WDATA[0] : analog_page[0]; // [RL10]
      next_r.trim_rate_sel = we_trim ? I_WDATA[`GPS_BIT_TRIM_RATE]
                                     : trim_rate[`GPS_BIT_TRIM_RATE]; // [RL11]
      next_r.pattern = {I_PATTERN_HIGH, we_pattern ? I_WDATA : pattern_low}; // [RL12] [RL13]
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign O_RDATA = r.rdata;
  assign O_RVALID = r.rvalid;
  assign O_ADC_PAGE_EN = r.pages.adc_page;
  assign O_CHAN_PAGE_EN = r.pages.chan_page;
  assign O_ANALOG_PAGE_EN = r.pages.analog_page;
  assign O_TRIM_LOAD_RATE_SEL = r.trim_rate_sel;
  assign O_USER_PATTERN_ONE = r.pattern;
  assign O_SOFT_DEVICE_RESET = r.soft_reset;

endmodule

// *** gps_host.sv ***
`timescale 1ns/1ps
module gps_host (
  input wire logic clk,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  logic [7:0] exp_q[$];
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // Released write data and read address show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= (a == 8'h00) ? (d | 8'h80) : d;
    @(posedge clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    o_rd <= 1'b1;
    o_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule

// *** gps_regs_props.sv ***
`timescale 1ns/1ps
module gps_regs_props #(
  parameter logic [7:0] REVISION_CODE = 8'h5a
) (
  input wire logic I_CLK, I_RESET_N, I_WR, I_RD,
  input wire logic [7:0] I_ADDR, I_WDATA, I_PATTERN_HIGH, O_RDATA,
  input wire logic O_RVALID,
  input wire logic [7:0] O_ADC_PAGE_EN,
  input wire logic [6:0] O_CHAN_PAGE_EN,
  input wire logic O_ANALOG_PAGE_EN, O_TRIM_LOAD_RATE_SEL,
  input wire logic [15:0] O_USER_PATTERN_ONE,
  input wire logic O_SOFT_DEVICE_RESET
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Writes during the reset cycle are dropped
  wire logic wr_ok = I_WR && !O_SOFT_DEVICE_RESET;
  a_rvalid_follows_rd: assert property (O_RVALID == $past(I_RD))
    else $error("read answer timing wrong");
  a_soft_rst_pulse: assert property (wr_ok && I_ADDR == 8'h00 && I_WDATA[0] |=>
    O_SOFT_DEVICE_RESET ##1 !O_SOFT_DEVICE_RESET) else $error("soft reset pulse wrong");
  a_soft_rst_clear: assert property (O_SOFT_DEVICE_RESET |-> O_ADC_PAGE_EN == 8'h00 &&
    O_CHAN_PAGE_EN == 7'h00 && !O_ANALOG_PAGE_EN && !O_TRIM_LOAD_RATE_SEL &&
    O_USER_PATTERN_ONE[7:0] == 8'h00) else $error("soft reset left state");
  a_revision_fixed: assert property (I_RD && I_ADDR == 8'h04 |=> O_RDATA == REVISION_CODE)
    else $error("revision read wrong");
  a_adc_write: assert property (wr_ok && I_ADDR == 8'h11 |=> O_ADC_PAGE_EN == $past(I_WDATA))
    else $error("adc page write wrong");
  a_chan_write: assert property (wr_ok && I_ADDR == 8'h12 |=>
    {1'b0, O_CHAN_PAGE_EN} == ($past(I_WDATA) & 8'h7f)) else $error("chan page write wrong");
  a_analog_write: assert property (wr_ok && I_ADDR == 8'h13 |=>
    {7'h00, O_ANALOG_PAGE_EN} == ($past(I_WDATA) & 8'h01)) else $error("analog write wrong");
  a_trim_write: assert property (wr_ok && I_ADDR == 8'h64 && O_CHAN_PAGE_EN[0] |=>
    {6'h00, O_TRIM_LOAD_RATE_SEL, 1'b0} == ($past(I_WDATA) & 8'h02)) else $error("trim wrong");
  a_pattern_high: assert property ($past(I_RESET_N) |->
    O_USER_PATTERN_ONE[15:8] == $past(I_PATTERN_HIGH)) else $error("pattern high wrong");
endmodule
bind gps_regs gps_regs_props #(.REVISION_CODE(REVISION_CODE)) gps_regs_props_i (.I_CLK,
  .I_RESET_N, .I_WR, .I_RD, .I_ADDR, .I_WDATA, .I_PATTERN_HIGH, .O_RDATA, .O_RVALID,
  .O_ADC_PAGE_EN, .O_CHAN_PAGE_EN, .O_ANALOG_PAGE_EN, .O_TRIM_LOAD_RATE_SEL,
  .O_USER_PATTERN_ONE, .O_SOFT_DEVICE_RESET);

// *** gps_regs_test.sv ***
`timescale 1ns/1ps
`include "gps_defs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module gps_regs_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pat = 8'h00;
  logic wr, rd, rvalid, ana, trim, srst;
  logic [7:0] addr, wdata, rdata, adc, v, exp_rd;
  logic [6:0] chan;
  logic [15:0] upat;
  logic [31:0] seed = 32'h25;
  logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h11, 8'h12, 8'h13, 8'h55, 8'h64, 8'h8d};
  int error_cnt = 0;
  int checked = 0;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  always #4 clk = ~clk;
  always @(posedge clk) pat <= 8'(xs());
  gps_regs gps_regs_i (.I_CLK(clk), .I_RESET_N(rst_n), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
    .I_WDATA(wdata), .I_PATTERN_HIGH(pat), .O_RDATA(rdata), .O_RVALID(rvalid),
    .O_ADC_PAGE_EN(adc), .O_CHAN_PAGE_EN(chan), .O_ANALOG_PAGE_EN(ana),
    .O_TRIM_LOAD_RATE_SEL(trim), .O_USER_PATTERN_ONE(upat), .O_SOFT_DEVICE_RESET(srst));
  gps_host gps_host_i (.clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  // Sampled on the falling edge so registered outputs have settled
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (gps_host_i.exp_q.size() > 0) begin
        exp_rd = gps_host_i.exp_q.pop_front();
        `CHK(rdata, exp_rd)
      end else
        `CHK(rvalid, 1'b0)
    end else
      `CHK(rdata, 8'h00)
  end
  task automatic wchk(input logic [7:0] a, input logic [7:0] d);
    gps_host_i.wr(a, d);
    @(negedge clk);
  endtask
  task automatic report_and_stop();
    `CHK(gps_host_i.exp_q.size(), 0)
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) gps_host_i.rd(ra[i], (i == 1) ? `GPS_REVISION_DEFAULT : 8'h00);
    $display("reset values done");
    repeat (8) begin
      v = 8'(xs());
      wchk(8'h11, v);
      `CHK(adc, v)
      wchk(8'h12, v & 8'h7f);
      `CHK(chan, v[6:0])
      wchk(8'h13, v & 8'h01);
      `CHK(ana, v[0])
      gps_host_i.rd(8'h11, v);
      gps_host_i.rd(8'h12, v & 8'h7f);
      gps_host_i.rd(8'h13, v & 8'h01);
    end
    wchk(8'h04, v);
    gps_host_i.rd(8'h04, `GPS_REVISION_DEFAULT);
    $display("page select done");
    wchk(8'h12, 8'h00);
    wchk(8'h64, 8'h02);
    `CHK(trim, 1'b0)
    wchk(8'h12, 8'h01);
    wchk(8'h64, 8'h02);
    `CHK(trim, 1'b1)
    gps_host_i.rd(8'h64, 8'h02);
    wchk(8'h8d, v);
    `CHK(upat[7:0], v)
    gps_host_i.rd(8'h8d, v);
    $display("digital top done");
    wchk(8'h11, 8'ha5);
    wchk(8'h00, 8'h01);
    `CHK({srst, adc, chan, ana, trim}, 18'h20000)
    gps_host_i.rd(8'h00, 8'h00);
    wchk(8'h12, 8'h01);
    `CHK(srst, 1'b0)
    gps_host_i.rd(8'h8d, 8'h00);
    gps_host_i.rd(8'h64, 8'h00);
    repeat (4) @(posedge clk);
    $display("soft reset done");
    report_and_stop();
  end
endmodule
